/* File: bench/conv_control_props.sv */
`timescale 1ns/1ps
module conv_control_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire conv_ctrl_pkg::conv_cfg_t cfg,
  input wire logic cfg_write,
  input wire logic ext_trigger,
  input wire logic subsystem_clock_en,
  input wire logic alt_clock_en,
  input wire conv_ctrl_pkg::conv_status_t status
);
  // Last written word, so a write is judged against the one before it
  conv_ctrl_pkg::conv_cfg_t q_ff;
  logic bz, sc, en, pw, ok, run, bad_div;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q_ff <= '0;
    end else if (cfg_write) begin
      q_ff <= cfg;
    end
  end
  assign bz = status.conversion_busy_flag;
  assign sc = status.start_conversion_bit;
  assign en = cfg_write && cfg.enable_conversion_bit;
  assign pw = cfg.converter_power_bit;
  assign ok = !status.halted && !status.hung;
  assign run = bz && !sc && ok && cfg.conversion_sequence_mode != 2'h0;
  assign bad_div = cfg.conversion_clock_divider inside {3'h2, 3'h4, 3'h6};
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_go; en && pw && cfg.start_conversion_bit && q_ff.enable_conversion_bit && !bz
    && q_ff.converter_power_bit && ok && cfg.trigger_source == 2'h0 |=> bz && !sc; endproperty
  a_go: assert property (p_go) else $error("start ignored");
  property p_stuck; bz && sc |=> bz && sc; endproperty
  a_stuck: assert property (p_stuck) else $error("stuck busy released");
  property p_trig; en && pw && run && cfg.start_conversion_bit |-> ##[1:4] status.halted;
  endproperty
  a_trig: assert property (p_trig) else $error("retrigger did not halt");
  property p_pwr; en && !pw && run |-> ##[1:4] status.halted; endproperty
  a_pwr: assert property (p_pwr) else $error("power toggle did not halt");
  property p_rec; cfg_write && !cfg.enable_conversion_bit && !pw && status.halted
    && !status.hung |-> ##[1:2] !status.halted; endproperty
  a_rec: assert property (p_rec) else $error("halt not cleared");
  property p_hang; cfg_write && q_ff.conversion_clock_select == 2'h3 && bad_div
    && cfg.conversion_clock_select != 2'h3 && cfg.subsystem_clock_off_bit
    |-> ##[1:4] status.hung [*8]; endproperty
  a_hang: assert property (p_hang) else $error("clock switch hang missing");
  property p_sub; (q_ff.conversion_clock_select == 2'h3 && !subsystem_clock_en) [*3]
    |-> !status.result_valid; endproperty
  a_sub: assert property (p_sub) else $error("result without source clock");
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t %h %h", $time, (a), (b)); end end
bind conv_control conv_control_props props_u (.mclk(mclk), .nrst(nrst), .cfg(cfg),
  .cfg_write(cfg_write), .ext_trigger(ext_trigger), .status(status),
  .subsystem_clock_en(subsystem_clock_en), .alt_clock_en(alt_clock_en));
module tb;
  typedef conv_ctrl_pkg::conv_cfg_t cf_t;
  logic mclk, nrst, cfg_write, ext_trigger, sub_en;
  cf_t cfg, c;
  conv_ctrl_pkg::conv_status_t st;
  int bad_count, n_checks, pulses;
  conv_control dut_u (.mclk(mclk), .nrst(nrst), .cfg(cfg), .cfg_write(cfg_write),
    .ext_trigger(ext_trigger), .subsystem_clock_en(sub_en), .alt_clock_en(1'b1), .status(st));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic cf_t base(input logic [1:0] md, input logic [2:0] dv);
    base = '0;
    base.enable_conversion_bit = 1'b1;
    base.converter_power_bit = 1'b1;
    base.conversion_sequence_mode = md;
    base.conversion_clock_divider = dv;
  endfunction
  function automatic int n_res(input cf_t v);
    return (v.conversion_sequence_mode == 2'h1) ? int'(v.last_channel) + 1 : 1;
  endfunction
  task automatic wr(input cf_t v);
    @(posedge mclk);
    cfg <= v;
    cfg_write <= 1'b1;
    @(posedge mclk);
    cfg_write <= 1'b0;
  endtask
  // Enable and start in separate writes, never the stuck combination
  task automatic go(input cf_t v);
    v.start_conversion_bit = 1'b0;
    wr(v);
    v.start_conversion_bit = 1'b1;
    wr(v);
    #1 `CHK({st.conversion_busy_flag, st.start_conversion_bit}, 2'b10)
  endtask
  // Final result pulse rises as busy drops and is caught by the loop's last sample
  task automatic idle();
    pulses = 0;
    for (int i = 0; i <= 3000 && st.conversion_busy_flag !== 1'b0; i++) begin
      if (i == 3000) begin
        bad_count++;
        close_out();
      end
      @(posedge mclk);
      #1 pulses += int'(st.result_valid);
    end
    @(posedge mclk);
    #1 pulses += int'(st.result_valid);
  endtask
  task automatic rst();
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b1;
  endtask
  initial begin
    {nrst, cfg_write, ext_trigger, cfg} = '0;
    sub_en = 1'b1;
    void'($urandom(75));
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    for (int k = 0; k < 24; k++) begin
      c = base(2'($urandom_range(1)), 3'($urandom_range(7)));
      c.conversion_clock_select = 2'($urandom_range(3));
      c.last_channel = 4'($urandom_range(15));
      if (k < 6) begin
        c = base(2'(k / 2 + 1), 3'h3);
        go(c);
        c.start_conversion_bit = k[0] == 1'b0;
        c.converter_power_bit = k[0] == 1'b0;
        wr(c);
        repeat (4) @(posedge mclk);
        #1 `CHK(st.halted, 1'b1)
        wr('0);
        c = base(2'h1, 3'h0);
        c.enable_conversion_bit = 1'b0;
        wr(c);
        c.enable_conversion_bit = 1'b1;
      end
      go(c);
      idle();
      `CHK({st.halted, pulses}, {1'b0, n_res(c)})
      `CHK(st.channel, (c.conversion_sequence_mode == 2'h1) ? c.last_channel : 4'h0)
    end
    c = base(2'h0, 3'h3);
    c.trigger_source = 2'h1;
    wr(c);
    ext_trigger <= 1'b1;
    repeat (5) @(posedge mclk);
    ext_trigger <= 1'b0;
    idle();
    `CHK(pulses, 1)
    c.trigger_source = 2'h0;
    c.enable_conversion_bit = 1'b0;
    wr(c);
    c.enable_conversion_bit = 1'b1;
    c.start_conversion_bit = 1'b1;
    wr(c);
    repeat (30) @(posedge mclk);
    #1 `CHK({st.conversion_busy_flag, st.start_conversion_bit}, 2'b11)
    for (int d = 0; d < 8; d++) begin
      rst();
      c = base(2'h0, 3'(d));
      c.conversion_clock_select = 2'h3;
      c.subsystem_clock_off_bit = 1'b1;
      wr(c);
      c.conversion_clock_select = 2'($urandom_range(2));
      wr(c);
      repeat (4) @(posedge mclk);
      #1 `CHK(st.hung, 1'(d inside {2, 4, 6}))
    end
    rst();
    c = base(2'h0, 3'h0);
    c.conversion_clock_select = 2'h3;
    sub_en <= 1'b0;
    go(c);
    repeat (40) @(posedge mclk);
    sub_en <= 1'b1;
    #1 `CHK(st.conversion_busy_flag, 1'b1)
    idle();
    `CHK(pulses, 1)
    close_out();
  end
endmodule

/* File: include/conv_ctrl_pkg.sv */
// Operation
// RULE_01 - In manual trigger mode software checks busy clear before setting start.
// RULE_02 - In timer trigger mode the timer period exceeds sample plus conversion time.
// RULE_03 - Halt recovery: clear enable and power, set power, set enable, restart.
// RULE_04 - Toggling power while busy in sequence or repeat modes halts all conversions.
// RULE_05 - Software clears enable and waits for busy low before toggling power.
// RULE_06 - Clock select value 11 picks the subsystem clock as conversion clock.
// RULE_07 - Leaving subsystem clock while its off bit is set hangs with divide 3,5,7.
// RULE_08 - Software clears the off bit first or uses divide 1,2,4,6,8 only.
// RULE_09 - After non-software trigger, enable and start together leave busy stuck high.
// RULE_10 - Software sets enable and start in separate writes after changing trigger source.
// RULE_11 - Any new trigger while busy halts further conversions in sequence or repeat modes.
// RULE_12 - Busy sets at conversion start, clears at completion; start bit self-clears.
package conv_ctrl_pkg;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] SEQ_SINGLE = 2'h0;
  localparam logic [1:0] SEQ_SEQUENCE = 2'h1;
  localparam logic [1:0] SEQ_REPEAT_SINGLE = 2'h2;
  localparam logic [1:0] SEQ_REPEAT_SEQUENCE = 2'h3;
  localparam logic [1:0] CLK_SEL_SUBSYSTEM = 2'h3;
  localparam logic [1:0] TRIG_SOFTWARE = 2'h0;

  // ----------------------------------------
  // Counts and reset values
  // ----------------------------------------
  localparam logic [2:0] CONV_CLOCKS = 3'h5;
  localparam logic [3:0] CHAN_LAST_RESET = 4'h3;
  localparam logic [3:0] CHAN_FIRST = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_HALT = 2'b10,
    ST_STUCK = 2'b11
  } conv_state_t;

  typedef struct packed {
    logic enable_conversion_bit;
    logic start_conversion_bit;
    logic converter_power_bit;
    logic [1:0] conversion_sequence_mode;
    logic [1:0] trigger_source;
    logic [1:0] conversion_clock_select;
    logic [2:0] conversion_clock_divider;
    logic subsystem_clock_off_bit;
    logic [3:0] last_channel;
  } conv_cfg_t;

  typedef struct packed {
    logic conversion_busy_flag;
    logic start_conversion_bit;
    logic halted;
    logic hung;
    logic [3:0] channel;
    logic result_valid;
  } conv_status_t;

endpackage

/* File: src/conv_clock_divider.sv */
`timescale 1ns/1ps
module conv_clock_divider (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [2:0] divider,
  output logic tick
);
  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t cur_ff;
  div_state_t nxt_ff;

  // Divider field holds value-1, so 0 means divide by 1
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.tick = 1'b0;
    if (!run) begin
      nxt_ff.cnt = 3'h0;
    end else if (cur_ff.cnt >= divider) begin
      nxt_ff.cnt = 3'h0;
      nxt_ff.tick = 1'b1;
    end else begin
      nxt_ff.cnt = cur_ff.cnt + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign tick = cur_ff.tick;
endmodule

/* File: src/conv_control.sv */
`timescale 1ns/1ps
module conv_control (
  input wire logic mclk,
  input wire logic nrst,
  input wire conv_ctrl_pkg::conv_cfg_t cfg,
  input wire logic cfg_write,
  input wire logic ext_trigger,
  input wire logic subsystem_clock_en,
  input wire logic alt_clock_en,
  output conv_ctrl_pkg::conv_status_t status
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    conv_ctrl_pkg::conv_state_t state;
    logic enc;
    logic sc;
    logic pwr;
    logic [1:0] clk_sel;
    logic [1:0] last_trig;
    logic [2:0] conv_cnt;
    logic [3:0] channel;
    logic result_valid;
    logic [2:0] trig_sync;
    logic trig_lvl;
  } ctrl_state_t;

  ctrl_state_t cur_ff;
  ctrl_state_t nxt_ff;
  logic div_tick;
  logic clk_ok;
  logic trig_rise;
  logic repeat_mode;
  logic seq_mode;
  logic new_trigger;

  // ----------------------------------------
  // Conversion clock
  // ----------------------------------------
  assign clk_ok = (cur_ff.clk_sel == conv_ctrl_pkg::CLK_SEL_SUBSYSTEM) ?
                  subsystem_clock_en : alt_clock_en; // see RULE_06

  conv_clock_divider u_div (
    .mclk(mclk),
    .nrst(nrst),
    .run(cur_ff.pwr && clk_ok && cur_ff.state == conv_ctrl_pkg::ST_CONV),
    .divider(cfg.conversion_clock_divider),
    .tick(div_tick)
  );

  // Second and third stages must agree before an edge counts
  // Filtered level follows only once second and third stages agree
  assign trig_rise = cur_ff.trig_sync[1] && cur_ff.trig_sync[2] && !cur_ff.trig_lvl;
  assign seq_mode = cfg.conversion_sequence_mode != conv_ctrl_pkg::SEQ_SINGLE;
  assign repeat_mode = cfg.conversion_sequence_mode[1];

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.trig_sync = {cur_ff.trig_sync[1:0], ext_trigger};
    if (cur_ff.trig_sync[1] == cur_ff.trig_sync[2]) begin
      nxt_ff.trig_lvl = cur_ff.trig_sync[2];
    end
    nxt_ff.result_valid = 1'b0;
    new_trigger = 1'b0;
    if (cfg_write) begin
      nxt_ff.enc = cfg.enable_conversion_bit;
      nxt_ff.pwr = cfg.converter_power_bit;
      nxt_ff.clk_sel = cfg.conversion_clock_select;
      if (cfg.start_conversion_bit && cfg.trigger_source == conv_ctrl_pkg::TRIG_SOFTWARE) begin
        nxt_ff.sc = 1'b1;
        new_trigger = 1'b1;
      end
    end
    if (cfg.trigger_source != conv_ctrl_pkg::TRIG_SOFTWARE && trig_rise) begin
      new_trigger = cur_ff.enc;
    end
    unique case (cur_ff.state)
      conv_ctrl_pkg::ST_IDLE: begin
        if (cfg_write && cfg.enable_conversion_bit && cfg.start_conversion_bit &&
            !cur_ff.enc && cur_ff.last_trig != conv_ctrl_pkg::TRIG_SOFTWARE) begin
          nxt_ff.state = conv_ctrl_pkg::ST_STUCK; // see RULE_09
        end else if (new_trigger && nxt_ff.enc && nxt_ff.pwr &&
                     nxt_ff.state == conv_ctrl_pkg::ST_IDLE) begin
          nxt_ff.state = conv_ctrl_pkg::ST_CONV; // see RULE_12
          nxt_ff.sc = 1'b0; // see RULE_12
          nxt_ff.conv_cnt = 3'h0;
          nxt_ff.channel = conv_ctrl_pkg::CHAN_FIRST;
          nxt_ff.last_trig = cfg.trigger_source;
        end
      end
      conv_ctrl_pkg::ST_CONV: begin
        if (cfg_write && cfg.converter_power_bit != cur_ff.pwr && seq_mode) begin
          nxt_ff.state = conv_ctrl_pkg::ST_HALT; // see RULE_04
        end else if (new_trigger && seq_mode) begin
          nxt_ff.state = conv_ctrl_pkg::ST_HALT; // see RULE_11
        end else if (!nxt_ff.pwr) begin
          nxt_ff.state = conv_ctrl_pkg::ST_IDLE;
        end else if (div_tick) begin
          if (cur_ff.conv_cnt == conv_ctrl_pkg::CONV_CLOCKS) begin
            nxt_ff.conv_cnt = 3'h0;
            nxt_ff.result_valid = 1'b1;
            if (seq_mode && cur_ff.channel != cfg.last_channel) begin
              nxt_ff.channel = cur_ff.channel + 4'h1;
            end else if (repeat_mode && cur_ff.enc) begin
              nxt_ff.channel = conv_ctrl_pkg::CHAN_FIRST;
            end else begin
              nxt_ff.state = conv_ctrl_pkg::ST_IDLE; // see RULE_12
            end
          end else begin
            nxt_ff.conv_cnt = cur_ff.conv_cnt + 3'h1;
          end
        end
      end
      conv_ctrl_pkg::ST_HALT: begin
        // Only full power-down with enable low releases the halt
        if (!cur_ff.enc && !cur_ff.pwr) begin
          nxt_ff.state = conv_ctrl_pkg::ST_IDLE; // see RULE_03
          nxt_ff.sc = 1'b0;
        end
      end
      conv_ctrl_pkg::ST_STUCK: begin
        // Busy and start stay high; only reset clears this
        nxt_ff.sc = 1'b1; // see RULE_09
      end
    endcase
    // Checked after the state decode so that the hang wins over any completion
    if (cfg_write && cur_ff.clk_sel == conv_ctrl_pkg::CLK_SEL_SUBSYSTEM &&
        cfg.conversion_clock_select != conv_ctrl_pkg::CLK_SEL_SUBSYSTEM &&
        cfg.subsystem_clock_off_bit &&
        (cfg.conversion_clock_divider == 3'h2 || cfg.conversion_clock_divider == 3'h4 ||
         cfg.conversion_clock_divider == 3'h6)) begin
      nxt_ff.state = conv_ctrl_pkg::ST_STUCK; // see RULE_07
      nxt_ff.sc = cur_ff.sc;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '{state: conv_ctrl_pkg::ST_IDLE, enc: 1'b0, sc: 1'b0, pwr: 1'b0,
                  clk_sel: 2'h0, last_trig: conv_ctrl_pkg::TRIG_SOFTWARE, conv_cnt: 3'h0,
                  channel: conv_ctrl_pkg::CHAN_FIRST, result_valid: 1'b0, trig_sync: 3'h0,
                  trig_lvl: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign status.conversion_busy_flag = cur_ff.state == conv_ctrl_pkg::ST_CONV ||
                                       cur_ff.state == conv_ctrl_pkg::ST_STUCK;
  assign status.start_conversion_bit = cur_ff.sc;
  assign status.halted = cur_ff.state == conv_ctrl_pkg::ST_HALT;
  assign status.hung = cur_ff.state == conv_ctrl_pkg::ST_STUCK;
  assign status.channel = cur_ff.channel;
  assign status.result_valid = cur_ff.result_valid;
endmodule
